// >>> adc_seq_defines.svh
// Constants of the conversion sequencer: serial framing, register map, control fields and counts.
// Included by the sequencer, its tick divider and the pin synchroniser; holds definitions only.
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// Oscillator edges per decimation step
`define OSC_PRESCALE      448

// Decimation ratios, output-rate codes 0 to 7
`define RATIO_0           11'd1096
`define RATIO_1           11'd274
`define RATIO_2           11'd220
`define RATIO_3           11'd183
`define RATIO_4           11'd55
`define RATIO_5           11'd46
`define RATIO_6           11'd27
`define RATIO_7           11'd23

// Address byte layout
`define ABYTE_START       7
`define ABYTE_READ        6
`define ABYTE_REG         5:1
`define ABYTE_LSB         0

// Register addresses
`define REG_CTRL          5'h00
`define REG_INSEL         5'h01
`define REG_RESULT        5'h02
`define REG_OFFSET        5'h03

// Converter control word fields
`define CTRL_POWER        15
`define CTRL_RESTART      14
`define CTRL_SIGNED       13
`define CTRL_REPEAT       11
`define CTRL_RATE         7:5
`define CTRL_KIND         4:2

// Conversion kinds
`define KIND_NORMAL       3'h0
`define KIND_SYS_OFFSET   3'h1
`define KIND_SYS_GAIN     3'h2
`define KIND_SELF_OFFSET  3'h5
`define KIND_SELF_GAIN    3'h6
`define KIND_SELF_BOTH    3'h7

// Last bit index of each frame phase, then the bit counter's stop value
`define BIT_ADDR_LAST     5'd7
`define BIT_INSEL_LAST    5'd15
`define BIT_CTRL_LAST     5'd23
`define BIT_CAP           5'd24

// Conversion-cycle counts
`define FIRST_CYCLES      3'd4
`define NEXT_CYCLES       3'd1
`define CAL_CYCLES        3'd4
`define SETTLE_CYCLES     3'd5

`define SEL_OPEN_MIN      4'ha
`define UNIPOLAR_FLIP     16'h8000
`define SYNC_RESET        4'h2

`endif

// >>> adc_seq_pkg.sv
// Types shared by the conversion sequencer files.
// Assumes nothing of its surroundings.
package adc_seq_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_CAL_OFFSET,
    ST_CAL_GAIN
  } convState_t;

endpackage

// >>> pin_sync.sv
// Two-flop synchroniser for the serial pins and the oscillator.
// Assumes the inputs are asynchronous to clk; bit 1 (chip select) idles high.
`timescale 1ns/1ns
`include "adc_seq_defines.svh"

module pin_sync (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Pins in, synchronised out
  input  wire logic [3:0] din,
  output logic      [3:0] dout
);

  logic [3:0] meta_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= `SYNC_RESET;
      dout   <= `SYNC_RESET;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule // pin_sync

// >>> conv_tick_divider.sv
// Conversion-cycle tick: one pulse per PRESCALE x ratio oscillator edges.
// Assumes oscEdge is a one-cycle pulse per synchronised oscillator rising edge.
`timescale 1ns/1ns
`include "adc_seq_defines.svh"

module conv_tick_divider #(
  parameter int unsigned PRESCALE = `OSC_PRESCALE
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Control
  input  wire logic        restart,
  input  wire logic        oscEdge,
  input  wire logic [10:0] ratio,
  // Tick
  output logic             tick
);

  logic [15:0] preCnt_q;
  logic [10:0] ratioCnt_q;

  // Two chained counters avoid a 448 x ratio multiplier
  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      preCnt_q   <= 16'h0000;
      ratioCnt_q <= 11'h000;
      tick       <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (oscEdge) begin
        if (preCnt_q == 16'(PRESCALE - 1)) begin
          preCnt_q <= 16'h0000;
          if (ratioCnt_q == ratio - 11'd1) begin
            ratioCnt_q <= 11'h000;
            tick       <= 1'b1;
          end else begin
            ratioCnt_q <= ratioCnt_q + 11'd1;
          end
        end else begin
          preCnt_q <= preCnt_q + 16'h0001;
        end
      end
    end
  end

endmodule // conv_tick_divider

// >>> adc_conversion_sequencer.sv
// Conversion sequencer of a sigma-delta converter, with its 4-wire serial register port.
// Assumes a filter that presents a 24-bit two's complement sample on filterSample at each tick.
//
// Summary of operation
// - Sampling rate is oscillator frequency over 448 times decimation ratio.
// - Rate codes 0..7 map to ratios 1096,274,220,183,55,46,27,23.
// - First result after filter reset takes four cycles; repeats take one each.
// - Without filter reset a step needs up to five cycles to settle.
// - Kind 1,2 system cal; 5,6 self cal; 7 both; others normal.
// - Finished calibration clears kind, sets done, raises interrupt when unmasked.
// - Combined calibration runs offset then gain, signals done once.
// - After reset or calibration, stay idle until a start request.
// - Input-select write with quick-start restarts filter after eighth data bit.
// - Input-select read with quick-start starts at once after the address byte.
// - Host may abort a quick-start read frame early, harmlessly.
// - Quick start without repeat converts once and keeps the result.
// - Repeat mode converts until repeat or power bit is cleared.
// - Quick start sets filter-restart bit; first result clears it.
// - Input-select write without quick-start changes inputs only.
// - Powered down, both selectors are open.
// - Positive codes 0..9 select sources; other top-bit codes are open.
// - Negative codes 0..9 select sources; 1010 and above are open.
// - Input-select write takes effect at its last data bit.
// - Result holds 16 bits: unsigned when unipolar, two's complement bipolar.
// - Offset calibration stores its 24-bit value in the offset trim.
// - Control write with restart bit starts after its sixteenth bit.
// - Clearing repeat stops conversion, keeps last result, sends no filter reset.
`timescale 1ns/1ns
`include "adc_seq_defines.svh"

module adc_conversion_sequencer #(
  parameter int unsigned OSC_PRESCALE = `OSC_PRESCALE
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Serial port
  input  wire logic                    sclk,
  input  wire logic                    csN,
  input  wire logic                    sdi,
  output logic                         sdo,
  output logic                         sdoOe,
  // Oscillator and filter
  input  wire logic                    fastOscClock,
  input  wire logic [23:0]             filterSample,
  output logic                         filterReset,
  // Status and interrupt
  input  wire logic                    doneClear,
  input  wire logic                    doneMask,
  input  wire logic                    readyPinEnable,
  output logic                         doneFlag,
  output logic                         irqOut,
  output logic                         readyOut,
  output logic                         resultSettled,
  // Input selectors
  output logic [3:0]                   posSelect,
  output logic                         posOpen,
  output logic [3:0]                   negSelect,
  output logic                         negOpen,
  output adc_seq_pkg::convState_t      convPhase
);
  import adc_seq_pkg::*;

  function automatic logic [10:0] decimationRatio(input logic [2:0] rate);
    case (rate)
      3'h0:    decimationRatio = `RATIO_0;
      3'h1:    decimationRatio = `RATIO_1;
      3'h2:    decimationRatio = `RATIO_2;
      3'h3:    decimationRatio = `RATIO_3;
      3'h4:    decimationRatio = `RATIO_4;
      3'h5:    decimationRatio = `RATIO_5;
      3'h6:    decimationRatio = `RATIO_6;
      default: decimationRatio = `RATIO_7;
    endcase
  endfunction

  function automatic convState_t kindState(input logic [2:0] kind);
    case (kind)
      `KIND_SYS_OFFSET, `KIND_SELF_OFFSET, `KIND_SELF_BOTH: kindState = ST_CAL_OFFSET;
      `KIND_SYS_GAIN, `KIND_SELF_GAIN:                      kindState = ST_CAL_GAIN;
      default:                                              kindState = ST_CONVERT;
    endcase
  endfunction

  function automatic logic selOpen(input logic [3:0] code);
    selOpen = (code >= `SEL_OPEN_MIN);
  endfunction

  // Pin synchronisation
  logic [3:0] syncOut;
  logic       sclkS;
  logic       csNS;
  logic       sdiS;
  logic       oscS;
  logic       sclkPrev_q;
  logic       oscPrev_q;
  logic       sclkRise;
  logic       sclkFall;
  logic       oscEdge;

  pin_sync u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({fastOscClock, sdi, csN, sclk}),
    .dout  (syncOut)
  );

  assign sclkS    = syncOut[0];
  assign csNS     = syncOut[1];
  assign sdiS     = syncOut[2];
  assign oscS     = syncOut[3];
  assign sclkRise = sclkS & ~sclkPrev_q & ~csNS;
  assign sclkFall = ~sclkS & sclkPrev_q & ~csNS;
  assign oscEdge  = oscS & ~oscPrev_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclkPrev_q <= 1'b0;
      oscPrev_q  <= 1'b0;
    end else begin
      sclkPrev_q <= sclkS;
      oscPrev_q  <= oscS;
    end
  end

  // Serial framing
  logic [4:0]  bitCnt_q;
  logic [23:0] shift_q;
  logic [7:0]  addr_q;
  logic        frameOk_q;
  logic        reading_q;
  logic [23:0] txShift_q;
  logic [15:0] ctrl_q;
  logic [7:0]  insel_q;
  logic [15:0] result_q;
  logic [23:0] offset_q;
  logic [7:0]  newByte;
  logic [15:0] newWord;
  logic        addrDone;
  logic        quickRead;
  logic        inselWrite;
  logic        quickWrite;
  logic        ctrlWrite;
  logic        ctrlStart;
  logic [23:0] readWord;

  assign newByte    = {shift_q[6:0], sdiS};
  assign newWord    = {shift_q[14:0], sdiS};
  assign addrDone   = sclkRise && (bitCnt_q == `BIT_ADDR_LAST);
  assign quickRead  = addrDone && newByte[`ABYTE_START] && newByte[`ABYTE_READ] && newByte[`ABYTE_LSB]
                      && (newByte[`ABYTE_REG] == `REG_INSEL);
  assign inselWrite = sclkRise && (bitCnt_q == `BIT_INSEL_LAST) && frameOk_q && !reading_q
                      && (addr_q[`ABYTE_REG] == `REG_INSEL);
  assign quickWrite = inselWrite && addr_q[`ABYTE_LSB];
  assign ctrlWrite  = sclkRise && (bitCnt_q == `BIT_CTRL_LAST) && frameOk_q && !reading_q
                      && (addr_q[`ABYTE_REG] == `REG_CTRL);
  assign ctrlStart  = ctrlWrite && newWord[`CTRL_RESTART];

  always_comb begin
    case (newByte[`ABYTE_REG])
      `REG_CTRL:   readWord = {ctrl_q, 8'h00};
      `REG_INSEL:  readWord = {insel_q, 16'h0000};
      `REG_RESULT: readWord = {result_q, 8'h00};
      `REG_OFFSET: readWord = offset_q;
      default:     readWord = 24'h000000;
    endcase
  end

  // Raising chip select at any bit simply drops the frame
  always_ff @(posedge clk) begin
    if (!rst_n || csNS) begin
      bitCnt_q  <= 5'd0;
      shift_q   <= 24'h000000;
      addr_q    <= 8'h00;
      frameOk_q <= 1'b0;
      reading_q <= 1'b0;
      txShift_q <= 24'h000000;
    end else if (sclkRise) begin
      shift_q <= {shift_q[22:0], sdiS};
      if (bitCnt_q != `BIT_CAP) begin
        bitCnt_q <= bitCnt_q + 5'd1;
      end
      if (addrDone) begin
        addr_q    <= newByte;
        frameOk_q <= newByte[`ABYTE_START];
        reading_q <= newByte[`ABYTE_START] & newByte[`ABYTE_READ];
        txShift_q <= readWord;
      end
    end else if (sclkFall && reading_q && (bitCnt_q > 5'd8)) begin
      txShift_q <= {txShift_q[22:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sdo   <= 1'b0;
      sdoOe <= 1'b0;
    end else begin
      sdo   <= txShift_q[23];
      sdoOe <= ~csNS & reading_q;
    end
  end

  // Conversion engine signals
  convState_t  state_q;
  logic [2:0]  kind_q;
  logic [2:0]  rate_q;
  logic        signed_q;
  logic        repeatRun_q;
  logic        firstConv_q;
  logic [2:0]  cycCnt_q;
  logic [2:0]  settleCnt_q;
  logic [15:0] startCfg;
  logic        powerNow;
  logic        startAcc;
  logic        tick;
  logic [2:0]  target;
  logic        cycHit;
  logic        stopRun;
  logic        resultLoad;
  logic        calEnd;
  logic        calFinish;
  logic        clearRestart;

  assign startCfg     = ctrlWrite ? newWord : ctrl_q;
  assign powerNow     = ctrl_q[`CTRL_POWER];
  assign startAcc     = (quickRead || quickWrite || ctrlStart) && startCfg[`CTRL_POWER];
  assign target       = (state_q == ST_CONVERT) ? (firstConv_q ? `FIRST_CYCLES : `NEXT_CYCLES) : `CAL_CYCLES;
  assign cycHit       = tick && (cycCnt_q == target - 3'd1);
  assign stopRun      = (state_q == ST_CONVERT) && repeatRun_q && !ctrl_q[`CTRL_REPEAT];
  assign resultLoad   = (state_q == ST_CONVERT) && cycHit && powerNow && !stopRun && !startAcc;
  assign calEnd       = ((state_q == ST_CAL_OFFSET) || (state_q == ST_CAL_GAIN)) && cycHit && powerNow && !startAcc;
  assign calFinish    = calEnd && ((state_q == ST_CAL_GAIN) || (kind_q != `KIND_SELF_BOTH));
  assign clearRestart = (resultLoad && firstConv_q) || calFinish;

  conv_tick_divider #(
    .PRESCALE (OSC_PRESCALE)
  ) u_div (
    .clk     (clk),
    .rst_n   (rst_n),
    .restart (startAcc),
    .oscEdge (oscEdge),
    .ratio   (decimationRatio(rate_q)),
    .tick    (tick)
  );

  // Control word; hardware writes the restart and kind fields back
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= 16'h0000;
    end else if (ctrlWrite) begin
      ctrl_q <= newWord;
    end else begin
      if (quickRead || quickWrite) begin
        ctrl_q[`CTRL_RESTART] <= 1'b1;
      end
      if (clearRestart) begin
        ctrl_q[`CTRL_RESTART] <= 1'b0;
      end
      if (calFinish) begin
        ctrl_q[`CTRL_KIND] <= `KIND_NORMAL;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      insel_q <= 8'h00;
    end else if (inselWrite) begin
      insel_q <= newByte;
    end
  end

  // Rate, kind, sign and repeat latch at start; power and a cleared repeat bit act at once, other control writes apply with the next start
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q     <= ST_IDLE;
      kind_q      <= `KIND_NORMAL;
      rate_q      <= 3'h0;
      signed_q    <= 1'b0;
      repeatRun_q <= 1'b0;
      firstConv_q <= 1'b0;
      cycCnt_q    <= 3'd0;
      filterReset <= 1'b0;
    end else begin
      filterReset <= 1'b0;
      if (startAcc) begin
        kind_q      <= startCfg[`CTRL_KIND];
        rate_q      <= startCfg[`CTRL_RATE];
        signed_q    <= startCfg[`CTRL_SIGNED];
        repeatRun_q <= startCfg[`CTRL_REPEAT];
        firstConv_q <= 1'b1;
        cycCnt_q    <= 3'd0;
        filterReset <= 1'b1;
        state_q     <= kindState(startCfg[`CTRL_KIND]);
      end else if (!powerNow) begin
        state_q <= ST_IDLE;
      end else begin
        case (state_q)
          ST_IDLE: begin
            cycCnt_q <= 3'd0;
          end
          ST_CONVERT: begin
            if (stopRun) begin
              state_q <= ST_IDLE;
            end else if (cycHit) begin
              cycCnt_q    <= 3'd0;
              firstConv_q <= 1'b0;
              if (!repeatRun_q) begin
                state_q <= ST_IDLE;
              end
            end else if (tick) begin
              cycCnt_q <= cycCnt_q + 3'd1;
            end
          end
          ST_CAL_OFFSET: begin
            if (cycHit) begin
              cycCnt_q <= 3'd0;
              state_q  <= (kind_q == `KIND_SELF_BOTH) ? ST_CAL_GAIN : ST_IDLE;
            end else if (tick) begin
              cycCnt_q <= cycCnt_q + 3'd1;
            end
          end
          ST_CAL_GAIN: begin
            if (cycHit) begin
              cycCnt_q <= 3'd0;
              state_q  <= ST_IDLE;
            end else if (tick) begin
              cycCnt_q <= cycCnt_q + 3'd1;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  assign convPhase = state_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result_q <= 16'h0000;
      offset_q <= 24'h000000;
    end else begin
      if (resultLoad) begin
        result_q <= signed_q ? filterSample[23:8] : (filterSample[23:8] ^ `UNIPOLAR_FLIP);
      end
      if (calEnd && (state_q == ST_CAL_OFFSET)) begin
        offset_q <= filterSample;
      end
    end
  end

  // Input change without filter reset: results flagged unsettled for a while
  always_ff @(posedge clk) begin
    if (!rst_n || startAcc) begin
      settleCnt_q   <= 3'd0;
      resultSettled <= 1'b0;
    end else begin
      if (inselWrite && (state_q == ST_CONVERT)) begin
        settleCnt_q <= `SETTLE_CYCLES;
      end else if (resultLoad && (settleCnt_q != 3'd0)) begin
        settleCnt_q <= settleCnt_q - 3'd1;
      end
      if (resultLoad) begin
        resultSettled <= (settleCnt_q <= 3'd1);
      end
    end
  end

  // Done flag: a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      doneFlag <= 1'b0;
      irqOut   <= 1'b0;
      readyOut <= 1'b0;
    end else begin
      if (resultLoad || calFinish) begin
        doneFlag <= 1'b1;
      end else if (doneClear) begin
        doneFlag <= 1'b0;
      end
      irqOut   <= doneFlag & doneMask;
      readyOut <= doneFlag & doneMask & readyPinEnable;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      posSelect <= 4'h0;
      negSelect <= 4'h0;
      posOpen   <= 1'b1;
      negOpen   <= 1'b1;
    end else begin
      posSelect <= insel_q[7:4];
      negSelect <= insel_q[3:0];
      posOpen   <= !powerNow || selOpen(insel_q[7:4]);
      negOpen   <= !powerNow || selOpen(insel_q[3:0]);
    end
  end

  // Checks
  logic [2:0] ticksSince_q;
  always_ff @(posedge clk) begin
    if (!rst_n || startAcc) begin
      ticksSince_q <= 3'd0;
    end else if (tick && (ticksSince_q != 3'd7)) begin
      ticksSince_q <= ticksSince_q + 3'd1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_calDone;
    calFinish ##1 (ctrl_q[`CTRL_KIND] == `KIND_NORMAL);
  endsequence
  sequence s_singleEnd;
    resultLoad && !repeatRun_q ##1 (state_q == ST_IDLE);
  endsequence

  property p_firstFour;
    (resultLoad && firstConv_q) |-> (ticksSince_q == 3'd3);
  endproperty
  a_firstFour: assert property (p_firstFour) else $error("first result not on fourth cycle");
  property p_calClear;
    calFinish |-> s_calDone ##0 doneFlag;
  endproperty
  a_calClear: assert property (p_calClear) else $error("calibration end left kind or done wrong");
  property p_combinedOnce;
    (calEnd && state_q == ST_CAL_OFFSET && kind_q == `KIND_SELF_BOTH) |=> (state_q == ST_CAL_GAIN) && !$rose(doneFlag);
  endproperty
  a_combinedOnce: assert property (p_combinedOnce) else $error("combined calibration signalled early");
  property p_single;
    (resultLoad && !repeatRun_q) |-> s_singleEnd;
  endproperty
  a_single: assert property (p_single) else $error("single conversion did not stop");
  property p_quickRead;
    (quickRead && powerNow) |=> filterReset && ctrl_q[`CTRL_RESTART];
  endproperty
  a_quickRead: assert property (p_quickRead) else $error("quick-start read did not start");
  property p_repeatStop;
    (stopRun && !startAcc && powerNow) |=> (state_q == ST_IDLE) && $stable(result_q);
  endproperty
  a_repeatStop: assert property (p_repeatStop) else $error("repeat clear did not stop");
  property p_openOff;
    !powerNow |=> posOpen && negOpen;
  endproperty
  a_openOff: assert property (p_openOff) else $error("selectors not open while powered down");
  property p_negOpen;
    (insel_q[3:0] >= 4'ha) |=> negOpen;
  endproperty
  a_negOpen: assert property (p_negOpen) else $error("negative selector not open");
  property p_irq;
    (doneFlag && doneMask) |=> irqOut;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

endmodule // adc_conversion_sequencer

// >>> serial_host.sv
// Host side of the 4-wire serial port: MSB first, data set on falling, read on rising.
// Assumes clk is the system clock; sclk half period is 4 clk, still between frames.
`timescale 1ns/1ns
module serial_host (
  // Clock
  input  wire logic clk,
  // Serial port
  output logic      sclk,
  output logic      csN,
  output logic      sdi,
  input  wire logic sdo
);
  initial begin
    sclk = 1'b0;
    csN  = 1'b1;
    sdi  = 1'b1;
  end
  // Frame of n bits; ending early is legal
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    @(posedge clk) #2 csN = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = tx[i];
      repeat (4) @(posedge clk);
      #2 sclk = 1'b1;
      rx = {rx[30:0], sdo};
      repeat (4) @(posedge clk);
      #2 sclk = 1'b0;
    end
    repeat (4) @(posedge clk);
    #2 csN = 1'b1;
    // Released line shows no stale bit
    sdi = ~sdi;
    repeat (4) @(posedge clk) #2;
  endtask
endmodule // serial_host

// >>> adc_conversion_sequencer_tb.sv
// Self-checking bench of the conversion sequencer, host model on the serial port.
// Assumes OSC_PRESCALE of 2 and a 200 ns oscillator, so one tick at rate 7 is 230 clk.
`timescale 1ns/1ns
module adc_conversion_sequencer_tb;
  import adc_seq_pkg::*;
  logic        clk, rst_n, sclk, csN, sdi, sdo, sdoOe, fastOscClock, filterReset;
  logic [23:0] filterSample;
  logic        doneClear, doneMask, readyPinEnable, doneFlag, irqOut, readyOut, resultSettled;
  logic [3:0]  posSelect, negSelect;
  logic        posOpen, negOpen;
  convState_t  convPhase;
  logic [31:0] rd;
  int          num_errors = 0;
  int          num_checks = 0;
  int          numFilterResets = 0;
  int          numOeCycles = 0;
  convState_t  kindPhase [1:6] = '{ST_CAL_OFFSET, ST_CAL_GAIN, ST_CONVERT, ST_CONVERT, ST_CAL_OFFSET, ST_CAL_GAIN};

  adc_conversion_sequencer #(.OSC_PRESCALE(2)) dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .csN(csN),
    .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe), .fastOscClock(fastOscClock), .filterSample(filterSample),
    .filterReset(filterReset), .doneClear(doneClear), .doneMask(doneMask), .readyPinEnable(readyPinEnable),
    .doneFlag(doneFlag), .irqOut(irqOut), .readyOut(readyOut), .resultSettled(resultSettled),
    .posSelect(posSelect), .posOpen(posOpen), .negSelect(negSelect), .negOpen(negOpen), .convPhase(convPhase));
  serial_host host (.clk(clk), .sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    fastOscClock = 1'b0;
    forever #100 fastOscClock = ~fastOscClock;
  end
  // Pulse and enable counts, taken on the edge before the design updates them
  always @(posedge clk) begin
    if (filterReset === 1'b1)
      numFilterResets++;
    if (sdoOe === 1'b1)
      numOeCycles++;
  end

  task automatic complete_run();
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic clear_done();
    @(posedge clk) #2 doneClear = 1'b1;
    @(posedge clk) #2 doneClear = 1'b0;
  endtask
  task automatic wait_done();
    int i;
    for (i = 0; i < 5000 && doneFlag !== 1'b1; i++)
      @(posedge clk) #2;
    if (i == 5000) begin
      num_errors++;
      complete_run();
    end
    repeat (3) @(posedge clk) #2;
  endtask

  task automatic t_reset();
    check({posOpen, negOpen, doneFlag, irqOut}, 4'hc);
    check(convPhase, ST_IDLE);
    check(numFilterResets, 0);
    host.xfer(16, 32'hc200, rd);
    check(rd[7:0], 8'h00);
    host.xfer(24, 32'hc40000, rd);
    check(rd[15:0], 16'h0000);
    check(numOeCycles != 0, 1'b1);
  endtask
  task automatic t_single();
    filterSample = 24'h123456;
    host.xfer(24, 32'h80a0e0, rd);
    clear_done();
    host.xfer(16, 32'h8323, rd);
    check({posSelect, negSelect, posOpen, negOpen}, 10'h08c);
    check(numFilterResets, 1);
    check(convPhase, ST_CONVERT);
    host.xfer(24, 32'hc00000, rd);
    check(rd[14], 1'b1);
    wait_done();
    check(convPhase, ST_IDLE);
    check({irqOut, readyOut}, 2'b11);
    @(posedge clk) #2 doneMask = 1'b0;
    repeat (2) @(posedge clk) #2;
    check({irqOut, readyOut}, 2'b00);
    doneMask = 1'b1;
    readyPinEnable = 1'b0;
    repeat (2) @(posedge clk) #2;
    check({irqOut, readyOut}, 2'b10);
    readyPinEnable = 1'b1;
    host.xfer(24, 32'hc40000, rd);
    check(rd[15:0], 16'h1234);
    host.xfer(24, 32'hc00000, rd);
    check(rd[14], 1'b0);
  endtask
  task automatic t_cal();
    filterSample = 24'h00abcd;
    clear_done();
    host.xfer(24, 32'h80c0fc, rd);
    check(convPhase, ST_CAL_OFFSET);
    check(numFilterResets, 2);
    // Offset takes four ticks, so gain runs by tick five
    repeat (1150) @(posedge clk) #2;
    check({convPhase, doneFlag}, {ST_CAL_GAIN, 1'b0});
    wait_done();
    check(convPhase, ST_IDLE);
    check(irqOut, 1'b1);
    host.xfer(24, 32'hc00000, rd);
    check(rd[4:2], 3'h0);
    host.xfer(32, 32'hc6000000, rd);
    check(rd[23:0], 24'h00abcd);
    // Each of kinds 1 to 6 starts in its own phase and ends idle
    for (int k = 1; k <= 6; k++) begin
      clear_done();
      host.xfer(24, 32'h80c0e0 | (k << 2), rd);
      check(convPhase, kindPhase[k]);
      wait_done();
      check(convPhase, ST_IDLE);
    end
  endtask
  task automatic t_repeat();
    filterSample = 24'h123456;
    host.xfer(24, 32'h8088c0, rd);
    check(convPhase, ST_IDLE);
    clear_done();
    host.xfer(8, 32'hc3, rd);
    check(convPhase, ST_CONVERT);
    // Rate 6 ticks every 270 clk: no result yet where rate 7 would have one
    repeat (1000) @(posedge clk) #2;
    check(doneFlag, 1'b0);
    wait_done();
    check(resultSettled, 1'b1);
    host.xfer(24, 32'hc40000, rd);
    check(rd[15:0], 16'h9234);
    clear_done();
    wait_done();
    check(convPhase, ST_CONVERT);
    host.xfer(16, 32'h8223, rd);
    clear_done();
    wait_done();
    check({convPhase, resultSettled}, {ST_CONVERT, 1'b0});
    host.xfer(24, 32'h8080e0, rd);
    check(convPhase, ST_IDLE);
    // A changed sample must not reach the kept result
    filterSample = 24'h654321;
    repeat (300) @(posedge clk) #2;
    host.xfer(24, 32'hc40000, rd);
    check(rd[15:0], 16'h9234);
  endtask
  task automatic t_insel();
    int oe0;
    oe0 = numOeCycles;
    host.xfer(16, 32'h829a, rd);
    check({posSelect, posOpen, negOpen, convPhase}, {4'h9, 2'b01, ST_IDLE});
    host.xfer(16, 32'h82b9, rd);
    check({posOpen, negOpen, negSelect}, {2'b10, 4'h9});
    host.xfer(16, 32'h8200, rd);
    check({posOpen, negOpen}, 2'b00);
    host.xfer(24, 32'h800000, rd);
    check({posOpen, negOpen}, 2'b11);
    check(numOeCycles, oe0);
  endtask

  initial begin
    rst_n = 1'b0;
    filterSample = 24'h0;
    doneClear = 1'b0;
    doneMask = 1'b1;
    readyPinEnable = 1'b1;
    repeat (3) @(posedge clk);
    #2 rst_n = 1'b1;
    repeat (4) @(posedge clk) #2;
    t_reset();
    t_single();
    t_cal();
    t_repeat();
    t_insel();
    complete_run();
  end
endmodule // adc_conversion_sequencer_tb
